// ==== src/eci_pkg.sv ====
// package for the encoder counter input block: register map, fields, enums, timing
package eci_pkg;
  // register byte offsets
  localparam logic [11:0] ECI_CTRL_OFS = 12'h000; // mode and option control
  localparam logic [11:0] ECI_START_OFS = 12'h004; // start value
  localparam logic [11:0] ECI_COUNT_OFS = 12'h008; // live count, read only
  localparam logic [11:0] ECI_CAPT_OFS = 12'h00c; // captured count, read only
  localparam logic [11:0] ECI_STAT_OFS = 12'h010; // status, write one to clear
  // control field positions
  localparam int ECI_SIG_LSB = 0; // signal type, 3 bits
  localparam int ECI_EVAL_LSB = 3; // evaluation, 2 bits
  localparam int ECI_INV_BIT = 5; // direction inversion
  localparam int ECI_SWDIR_BIT = 6; // pulse-only direction, 1 = down
  localparam int ECI_NREACT_LSB = 7; // reaction to zero track, 2 bits
  localparam int ECI_PERIOD_BIT = 9; // periodic synchronisation
  localparam int ECI_FILT_LSB = 10; // filter setting, 4 bits
  localparam int ECI_DISYNC_BIT = 14; // digital input gates zero sync
  localparam int ECI_DICAPT_BIT = 15; // digital input capture enable
  localparam int ECI_DIEDGE_BIT = 16; // digital input sync on edge
  localparam int ECI_CNTREF_BIT = 17; // count value used as reference
  localparam int ECI_CAPPER_BIT = 18; // periodic capture
  // reset values
  localparam logic [31:0] ECI_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ECI_START_RST = 32'h0000_0000;
  // clock and filter times
  localparam int ECI_CLK_HZ = 40_000_000;
  localparam int ECI_FILT_NUM = 13;
  // minimum pulse/break times in ns, 100 Hz first
  localparam int ECI_FILT_NS [ECI_FILT_NUM] = '{4_000_000, 2_000_000, 800_000, 400_000, 200_000,
    80_000, 40_000, 20_000, 8_000, 4_000, 2_000, 800, 400};
  localparam int ECI_FILT_W = 18; // fits 160000 cycles
  typedef enum logic [2:0] {
    ECI_SIG_QUAD = 3'h0, ECI_SIG_QUADN = 3'h1, ECI_SIG_PDIR = 3'h2, ECI_SIG_PULSE = 3'h3,
    ECI_SIG_UPDN = 3'h4
  } eci_sig_t;
  typedef enum logic [1:0] {ECI_EV_SINGLE = 2'h0, ECI_EV_DOUBLE = 2'h1, ECI_EV_QUAD = 2'h2} eci_eval_t;
  typedef enum logic [1:0] {ECI_N_NONE = 2'h0, ECI_N_SYNC = 2'h1, ECI_N_CAPT = 2'h2} eci_nreact_t;
  // filter state of one input
  typedef struct packed {
    logic [1:0] sync; // two-stage synchroniser
    logic level; // filtered level
    logic [ECI_FILT_W-1:0] cnt; // stable-time counter
  } eci_filt_t;
  // whole block state
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] start;
    logic [31:0] count;
    logic [31:0] capt;
    logic sync_done; // sticky: a synchronisation happened
    logic capt_done; // sticky: a capture happened
    logic di_prev; // last digital input level
    logic [31:0] rdata;
  } eci_state_t;
endpackage

// ==== src/eci_counter_input.sv ====
// encoder counter input: filtering, signal decoding, zero-track handling, apb registers
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module eci_counter_input
  import eci_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // encoder tracks and digital input
  input wire logic track_a,
  input wire logic track_b,
  input wire logic track_n,
  input wire logic dig_in,
  // results
  output logic [31:0] count_value,
  output logic [31:0] captured_count_output
);
  // the time table is in nanoseconds and the clock is fixed, so each
  // threshold folds to one constant per selection in synthesis
  // codes past the fastest setting clamp to it rather than to the slowest,
  // so a stray write never slows the inputs to the 4 ms setting
  // filter thresholds in cycles, rounded up, never below one
  function automatic logic [ECI_FILT_W-1:0] eci_thresh(input logic [3:0] sel);
    int idx;
    longint cyc;
    idx = (sel >= 4'(ECI_FILT_NUM)) ? ECI_FILT_NUM - 1 : int'(sel);
    cyc = (longint'(ECI_FILT_NS[idx]) * ECI_CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
    if (cyc < 1) cyc = 1;
    return ECI_FILT_W'(cyc);
  endfunction

  eci_state_t st_reg, st_next; // block state
  eci_filt_t [2:0] flt_reg; // filters for a, b, n
  eci_filt_t [2:0] flt_next;
  logic [2:0] raw_in; // synchroniser inputs
  logic [2:0] lvl; // filtered levels
  logic [ECI_FILT_W-1:0] thresh; // current filter threshold
  assign raw_in = {track_n, track_b, track_a};

  // synchroniser and filter share one state struct per track;
  // the first flop feeds only the second, nothing else reads it
  // the counter runs only while the synchronised input differs from the
  // accepted level, so a glitch shorter than the threshold leaves no trace
  // limitation: a level that flips faster than the threshold is never seen,
  // which is exactly what a minimum pulse and break time asks for
  // one filter per track; a change must hold past threshold before it is seen
  for (genvar g = 0; g < 3; g++) begin : g_filt
    always_comb begin
      flt_next[g] = flt_reg[g];
      flt_next[g].sync = {flt_reg[g].sync[0], raw_in[g]};
      if (flt_reg[g].sync[1] == flt_reg[g].level) begin
        flt_next[g].cnt = '0;
      end else if (flt_reg[g].cnt + 1'b1 >= thresh) begin
        flt_next[g].level = flt_reg[g].sync[1];
        flt_next[g].cnt = '0;
      end else begin
        flt_next[g].cnt = flt_reg[g].cnt + 1'b1; // short glitch restarts on return
      end
    end
    assign lvl[g] = flt_reg[g].level;
  end

  // decoded controls, all taken straight from the control register;
  // an illegal signal type decodes to no counting at all
  // the inversion bit is masked here for non-quadrature types, so software
  // may leave it set when switching type without side effects
  // decoded controls
  eci_sig_t sig;
  eci_eval_t evl;
  eci_nreact_t nre;
  logic is_quad; // quadrature type selected
  logic a_prev, b_prev, n_prev; // last filtered levels
  logic a_rise, a_fall, b_edge, n_rise;
  logic step_up, step_dn; // count pulses
  logic n_sync, n_capt, di_edge, sync_ev, capt_ev;
  logic apb_wr, apb_rd;
  assign thresh = eci_thresh(st_reg.ctrl[ECI_FILT_LSB +: 4]);
  assign sig = eci_sig_t'(st_reg.ctrl[ECI_SIG_LSB +: 3]);
  assign evl = eci_eval_t'(st_reg.ctrl[ECI_EVAL_LSB +: 2]);
  assign nre = eci_nreact_t'(st_reg.ctrl[ECI_NREACT_LSB +: 2]);
  assign is_quad = (sig == ECI_SIG_QUAD) || (sig == ECI_SIG_QUADN);
  // apb decode: setup phase latches read data, access phase commits writes
  // pready is tied high, so each access phase lasts exactly one cycle
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  // the filter registers and the delayed levels live beside the state struct
  // because the generate loop needs one element per track;
  // every reset value is a constant, nothing is loaded from a port
  // previous filtered levels, kept separately from the state struct
  logic [2:0] lvl_d_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_d_reg <= 3'h0;
      flt_reg <= '0;
      st_reg <= '0;
    end else begin
      lvl_d_reg <= lvl;
      flt_reg <= flt_next;
      st_reg <= st_next;
    end
  end
  // edge flags compare this cycle's filtered level with last cycle's one;
  // both reset low, matching the idle level of the tracks, so no false edge
  assign a_prev = lvl_d_reg[0];
  assign b_prev = lvl_d_reg[1];
  assign n_prev = lvl_d_reg[2];
  assign a_rise = lvl[0] && !a_prev;
  assign a_fall = !lvl[0] && a_prev;
  assign b_edge = lvl[1] != b_prev;
  assign n_rise = lvl[2] && !n_prev;

  // in quadrature the phase of b at an a edge gives the direction;
  // with quadruple evaluation a b edge counts only when a is quiet, so
  // two tracks moving in one cycle never count twice
  // trade-off: simultaneous a and b edges are a fault of the encoder and
  // are resolved by the a edge alone rather than flagged
  // up and down at once cancel; the up/down type with both pulses already decodes to neither
  // count direction and pulse decode per signal type
  always_comb begin
    logic up, dn, inv;
    up = 1'b0;
    dn = 1'b0;
    inv = st_reg.ctrl[ECI_INV_BIT] && is_quad;
    unique case (sig)
      ECI_SIG_QUAD, ECI_SIG_QUADN: begin
        unique case (evl)
          ECI_EV_DOUBLE: begin
            up = (a_rise && !lvl[1]) || (a_fall && lvl[1]);
            dn = (a_rise && lvl[1]) || (a_fall && !lvl[1]);
          end
          ECI_EV_QUAD: begin
            up = (a_rise && !lvl[1]) || (a_fall && lvl[1]) || (b_edge && (lvl[1] == lvl[0]) && !a_rise && !a_fall);
            dn = (a_rise && lvl[1]) || (a_fall && !lvl[1]) || (b_edge && (lvl[1] != lvl[0]) && !a_rise && !a_fall);
          end
          default: begin // single, also for unused code
            up = a_rise && !lvl[1];
            dn = a_fall && !lvl[1];
          end
        endcase
      end
      ECI_SIG_PDIR: begin
        up = a_rise && !lvl[1];
        dn = a_rise && lvl[1];
      end
      ECI_SIG_PULSE: begin
        up = a_rise && !st_reg.ctrl[ECI_SWDIR_BIT];
        dn = a_rise && st_reg.ctrl[ECI_SWDIR_BIT];
      end
      ECI_SIG_UPDN: begin
        up = a_rise && !(lvl[1] && !b_prev);
        dn = (lvl[1] && !b_prev) && !a_rise;
      end
      default: begin // illegal type counts nothing
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
    step_up = inv ? dn : up;
    step_dn = inv ? up : dn;
  end

  // zero-track reactions only exist with the quadrature-with-zero type;
  // any other type ignores the reaction field completely
  // the digital input is sampled raw here: it is taken as synchronous
  // and has no filter of its own
  // once mode holds off further syncs until software clears the status bit
  // zero-track and digital-input events
  assign n_sync = (sig == ECI_SIG_QUADN) && (nre == ECI_N_SYNC) && n_rise
                  && (!st_reg.ctrl[ECI_DISYNC_BIT] || dig_in);
  assign di_edge = dig_in && !st_reg.di_prev;
  assign sync_ev = (n_sync || (st_reg.ctrl[ECI_DIEDGE_BIT] && di_edge))
                   && (st_reg.ctrl[ECI_PERIOD_BIT] || !st_reg.sync_done);
  assign n_capt = (sig == ECI_SIG_QUADN) && (nre == ECI_N_CAPT) && n_rise
                  && st_reg.ctrl[ECI_CNTREF_BIT];
  assign capt_ev = (n_capt || (st_reg.ctrl[ECI_DICAPT_BIT] && di_edge))
                   && (st_reg.ctrl[ECI_CAPPER_BIT] || !st_reg.capt_done);

  // sync beats counting in the same cycle, so the start value is exact;
  // capture copies the count before that cycle's step or sync
  // status bits are set after the clear, so a same-cycle event wins
  // hazard: writes to count or capture places are dropped silently
  // main next-state: counter, capture, registers
  always_comb begin
    st_next = st_reg;
    st_next.di_prev = dig_in;
    if (capt_ev) begin
      st_next.capt = st_reg.count;
    end
    if (sync_ev) begin
      st_next.count = st_reg.start;
    end else if (step_up && !step_dn) begin
      st_next.count = st_reg.count + 32'h1;
    end else if (step_dn && !step_up) begin
      st_next.count = st_reg.count - 32'h1;
    end
    if (apb_wr) begin
      unique case (paddr)
        ECI_CTRL_OFS: st_next.ctrl = pwdata;
        ECI_START_OFS: st_next.start = pwdata;
        ECI_STAT_OFS: begin // write one clears, event wins
          if (pwdata[0]) st_next.sync_done = 1'b0;
          if (pwdata[1]) st_next.capt_done = 1'b0;
        end
        default: ;
      endcase
    end
    if (sync_ev) st_next.sync_done = 1'b1;
    if (capt_ev) st_next.capt_done = 1'b1;
    // read data captured in setup phase
    if (apb_rd) begin
      unique case (paddr)
        ECI_CTRL_OFS: st_next.rdata = st_reg.ctrl;
        ECI_START_OFS: st_next.rdata = st_reg.start;
        ECI_COUNT_OFS: st_next.rdata = st_reg.count;
        ECI_CAPT_OFS: st_next.rdata = st_reg.capt;
        ECI_STAT_OFS: st_next.rdata = {30'h0, st_reg.capt_done, st_reg.sync_done};
        default: st_next.rdata = 32'h0;
      endcase
    end
  end

  // outputs: data from flops, handshake tied
  // no error response exists; unmapped places read zero
  assign prdata = st_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign count_value = st_reg.count;
  assign captured_count_output = st_reg.capt;

  // assertions
  chk_zero_none_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (nre == ECI_N_NONE && !st_reg.ctrl[ECI_DIEDGE_BIT] && !apb_wr) |=> !$rose(st_reg.sync_done))
    else $error("sync happened with no reaction selected");
  chk_sync_loads_start: assert property (@(posedge pclk) disable iff (!presetn)
    sync_ev |=> st_reg.count == $past(st_reg.start))
    else $error("sync did not load start value");
  chk_capt_copies: assert property (@(posedge pclk) disable iff (!presetn)
    capt_ev |=> captured_count_output == $past(st_reg.count))
    else $error("capture did not copy count");
  chk_once_single: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.sync_done && !st_reg.ctrl[ECI_PERIOD_BIT]) |-> !sync_ev)
    else $error("once mode synced twice");
  chk_quadn_only: assert property (@(posedge pclk) disable iff (!presetn)
    (sig != ECI_SIG_QUADN) |-> !n_sync && !n_capt)
    else $error("zero reaction outside quadrature-with-zero");
  chk_updn_step: assert property (@(posedge pclk) disable iff (!presetn)
    (sig == ECI_SIG_UPDN && a_rise && !(lvl[1] && !b_prev) && !sync_ev) |=> count_value == $past(count_value) + 32'h1)
    else $error("up pulse did not increment");
  chk_single_b_high: assert property (@(posedge pclk) disable iff (!presetn)
    (is_quad && evl == ECI_EV_SINGLE && lvl[1]) |-> !step_up && !step_dn)
    else $error("single evaluation counted with B high");
  chk_filter_glitch: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(lvl[0]) |-> $past(flt_reg[0].cnt) + 18'h00001 >= $past(thresh))
    else $error("filter level changed before the threshold");
  chk_inv_quad_only: assert property (@(posedge pclk) disable iff (!presetn)
    (sig == ECI_SIG_PULSE && a_rise && !st_reg.ctrl[ECI_SWDIR_BIT]) |-> step_up && !step_dn)
    else $error("inversion acted outside quadrature");
  // double evaluation reacts to a edges only
  chk_double_a_only: assert property (@(posedge pclk) disable iff (!presetn)
    (is_quad && evl == ECI_EV_DOUBLE && !a_rise && !a_fall) |-> !step_up && !step_dn)
    else $error("double evaluation counted without an A edge");
  // quadruple evaluation gives one step for a lone b edge
  chk_quad_b_counts: assert property (@(posedge pclk) disable iff (!presetn)
    (is_quad && evl == ECI_EV_QUAD && b_edge && !a_rise && !a_fall) |-> step_up != step_dn)
    else $error("quadruple evaluation missed a B edge");
  // pulse and direction: b level picks the direction
  chk_pdir_level: assert property (@(posedge pclk) disable iff (!presetn)
    (sig == ECI_SIG_PDIR && a_rise) |-> (step_dn == lvl[1]) && (step_up == !lvl[1]))
    else $error("pulse direction not taken from B");
  // pulse only: the control bit picks the direction
  chk_pulse_swdir: assert property (@(posedge pclk) disable iff (!presetn)
    (sig == ECI_SIG_PULSE && a_rise) |-> step_dn == st_reg.ctrl[ECI_SWDIR_BIT])
    else $error("pulse direction not taken from control");
  // pulse/direction and pulse-only types ignore the evaluation field and b edges
  chk_eval_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    ((sig == ECI_SIG_PDIR || sig == ECI_SIG_PULSE) && !a_rise) |-> !step_up && !step_dn)
    else $error("pulse type counted without an A pulse");
  // a b pulse alone decrements in up/down mode
  chk_updn_down: assert property (@(posedge pclk) disable iff (!presetn)
    (sig == ECI_SIG_UPDN && lvl[1] && !b_prev && !a_rise && !sync_ev) |=> count_value == $past(count_value) - 32'h1)
    else $error("down pulse did not decrement");
  // a leading b counts up when not inverted
  chk_a_leads_up: assert property (@(posedge pclk) disable iff (!presetn)
    (is_quad && !st_reg.ctrl[ECI_INV_BIT] && a_rise && !lvl[1]) |-> step_up && !step_dn)
    else $error("A leading B did not count up");
  // inversion swaps the quadrature direction
  chk_inv_flips: assert property (@(posedge pclk) disable iff (!presetn)
    (is_quad && st_reg.ctrl[ECI_INV_BIT] && a_rise && !lvl[1]) |-> step_dn && !step_up)
    else $error("inversion did not swap direction");
  // no reaction selected: zero track leaves the counter alone
  chk_no_n_reaction: assert property (@(posedge pclk) disable iff (!presetn)
    (nre == ECI_N_NONE && !st_reg.ctrl[ECI_DIEDGE_BIT]) |-> !sync_ev && !n_capt)
    else $error("zero track acted with no reaction");
  // gated zero sync waits for the digital input
  chk_n_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.ctrl[ECI_DISYNC_BIT] && !dig_in && !st_reg.ctrl[ECI_DIEDGE_BIT]) |-> !sync_ev)
    else $error("zero sync ran with the gate closed");
  // periodic mode loads the start value at every zero pulse
  chk_periodic_every: assert property (@(posedge pclk) disable iff (!presetn)
    (sig == ECI_SIG_QUADN && nre == ECI_N_SYNC && n_rise && !st_reg.ctrl[ECI_DISYNC_BIT]
     && st_reg.ctrl[ECI_PERIOD_BIT]) |=> count_value == $past(st_reg.start))
    else $error("periodic zero sync missed");
  // digital-input edge sync follows the same frequency setting
  chk_di_sync_freq: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.ctrl[ECI_DIEDGE_BIT] && dig_in && !st_reg.di_prev && !st_reg.sync_done) |=> count_value == $past(st_reg.start))
    else $error("digital input sync missed");
  // zero capture needs the count-reference mode
  chk_capt_needs_ref: assert property (@(posedge pclk) disable iff (!presetn)
    (nre == ECI_N_CAPT && !st_reg.ctrl[ECI_CNTREF_BIT] && !st_reg.ctrl[ECI_DICAPT_BIT]) |-> !capt_ev)
    else $error("zero capture outside reference mode");
  // digital capture works beside zero capture
  chk_di_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg.ctrl[ECI_DICAPT_BIT] && dig_in && !st_reg.di_prev && !st_reg.capt_done)
    |=> captured_count_output == $past(count_value))
    else $error("digital capture missed");
  // the accepted level always comes from the second flop
  chk_filter_source: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(lvl[0]) |-> lvl[0] == $past(flt_reg[0].sync[1]))
    else $error("filter level not from synchroniser");
  // thresholds stay between the fastest and the slowest setting
  chk_thresh_range: assert property (@(posedge pclk) disable iff (!presetn)
    thresh >= 18'h00010 && thresh <= 18'h27100)
    else $error("filter threshold out of range");
  // start register takes written data
  chk_start_write: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && paddr == ECI_START_OFS) |=> st_reg.start == $past(pwdata))
    else $error("start value write lost");
  // a status clear sticks unless an event lands in the same cycle
  chk_stat_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && paddr == ECI_STAT_OFS && pwdata[0] && !sync_ev) |=> !st_reg.sync_done)
    else $error("sync status clear lost");
  // capture output moves only on a capture event
  chk_capt_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !capt_ev |=> $stable(captured_count_output))
    else $error("capture changed without event");
endmodule

// ==== test/eci_encoder_model.sv ====
// encoder model: drives tracks a, b and n with filter-safe level steps
`timescale 1ns/1ps
module eci_encoder_model (
  // clock
  input wire logic pclk,
  // encoder tracks
  output logic track_a,
  output logic track_b,
  output logic track_n
);
  logic [2:0] lines = 3'h0; // n, b, a; push-pull, so no idle float
  assign {track_n, track_b, track_a} = lines;

  // hold levels for n clock edges
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one full quadrature cycle; up means a leads b
  task automatic quad(input bit up);
    int j;
    for (int i = 0; i < 4; i++) begin
      j = (i % 2) ^ int'(!up);
      lines[j] <= ~lines[j];
      wait_cyc(24); // above the 16-cycle filter
    end
  endtask

  // one high pulse on line 0 a, 1 b, 2 n
  task automatic pulse(input int which, input int len);
    lines[which] <= 1'b1;
    wait_cyc(len);
    lines[which] <= 1'b0;
    wait_cyc(24);
  endtask

  // park track b at a level
  task automatic hold_b(input logic v);
    lines[1] <= v;
    wait_cyc(24);
  endtask
endmodule

// ==== test/encoder_counter_input_tb_top.sv ====
// testbench for the encoder counter input block
`timescale 1ns/1ps
module encoder_counter_input_tb_top;
  import eci_pkg::*;
  typedef struct {logic [31:0] ctrl; int act, n, usen, di, cnt, capt;} eci_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, track_a, track_b, track_n, dig_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, count_value, captured_count_output, rd;
  int n_fail = 0;
  int tests_run = 0;
  // act: 0 quad up, 1 quad down, 2 a pulses, 3 a pulses b high, 4 b pulses; start is 100
  eci_row_t rows [20] = '{
    '{32'h3000, 0, 3, 0, 0, 3, 0},
    '{32'h3008, 0, 3, 0, 0, 6, 0},
    '{32'h3010, 0, 3, 0, 0, 12, 0},
    '{32'h3010, 1, 2, 0, 0, -8, 0},
    '{32'h3030, 0, 2, 0, 0, -8, 0},
    '{32'h3002, 2, 3, 0, 0, 3, 0},
    '{32'h3002, 3, 3, 0, 0, -3, 0},
    '{32'h3003, 2, 3, 0, 0, 3, 0},
    '{32'h3043, 2, 3, 0, 0, -3, 0},
    '{32'h3033, 2, 3, 0, 0, 3, 0},
    '{32'h3004, 2, 3, 0, 0, 3, 0},
    '{32'h3004, 4, 3, 0, 0, -3, 0},
    '{32'h3001, 0, 2, 1, 0, 2, 0},
    '{32'h3081, 0, 2, 1, 0, 102, 0},
    '{32'h3281, 0, 2, 1, 0, 100, 0},
    '{32'h3080, 0, 2, 1, 0, 2, 0},
    '{32'h7081, 0, 2, 1, 0, 2, 0},
    '{32'h7081, 0, 2, 1, 1, 102, 0},
    '{32'h63101, 0, 2, 1, 0, 2, 2},
    '{32'h43101, 0, 2, 1, 0, 2, 0}
  };

  // 40 mhz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  eci_counter_input i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .track_a(track_a),
    .track_b(track_b), .track_n(track_n), .dig_in(dig_in), .count_value(count_value),
    .captured_count_output(captured_count_output));
  eci_encoder_model i_enc (.pclk(pclk), .track_a(track_a), .track_b(track_b), .track_n(track_n));

  // verdict and end of run
  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // compare seen against expected
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // six-cycle reset, returns just after an edge
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // one apb transfer; read data lands in rd at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // spare edge so the next setup never collides
  endtask

  // register read and compare
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check("prdata", rd, exp);
    check("pslverr", 32'(pslverr), 32'h0);
  endtask

  // covers synchroniser plus 16-cycle filter plus update
  task automatic idle();
    repeat (40) @(posedge pclk);
  endtask

  // main sequence: table rows, then hand-written cases
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    dig_in = 1'b0;
    for (int r = 0; r < 20; r++) begin
      do_reset();
      apb(1'b1, ECI_START_OFS, 32'h0000_0064);
      apb(1'b1, ECI_CTRL_OFS, rows[r].ctrl);
      dig_in <= rows[r].di[0];
      if (rows[r].act == 3) i_enc.hold_b(1'b1);
      if (rows[r].usen != 0) i_enc.pulse(2, 24);
      for (int k = 0; k < rows[r].n; k++) begin
        if (rows[r].act < 2) i_enc.quad(rows[r].act == 0);
        else i_enc.pulse(int'(rows[r].act == 4), 24);
      end
      idle();
      if (rows[r].usen != 0) i_enc.pulse(2, 24);
      idle();
      check("count", count_value, 32'(rows[r].cnt));
      check("capture", captured_count_output, 32'(rows[r].capt));
      i_enc.hold_b(1'b0);
    end
    // reset values, read-only count, unmapped place
    do_reset();
    rd_chk(ECI_CTRL_OFS, ECI_CTRL_RST);
    rd_chk(ECI_START_OFS, ECI_START_RST);
    apb(1'b1, ECI_COUNT_OFS, 32'h0000_0007);
    rd_chk(ECI_COUNT_OFS, 32'h0);
    rd_chk(12'h020, 32'h0);
    apb(1'b1, ECI_START_OFS, 32'h0000_0005);
    rd_chk(ECI_START_OFS, 32'h0000_0005);
    // a glitch under the 16-cycle filter must vanish
    apb(1'b1, ECI_CTRL_OFS, 32'h0000_3004);
    i_enc.pulse(0, 10);
    idle();
    check("glitch", count_value, 32'h0);
    i_enc.pulse(0, 20);
    idle();
    rd_chk(ECI_COUNT_OFS, 32'h1);
    // slowest filter swallows a 24-cycle pulse
    apb(1'b1, ECI_CTRL_OFS, 32'h0000_0004);
    i_enc.pulse(0, 24);
    idle();
    check("slow filter", count_value, 32'h1);
    // digital input edge syncs once until status is cleared
    apb(1'b1, ECI_START_OFS, 32'h0000_0064);
    apb(1'b1, ECI_CTRL_OFS, 32'h0001_3000);
    dig_in <= 1'b1;
    idle();
    check("di sync", count_value, 32'h0000_0064);
    dig_in <= 1'b0;
    i_enc.quad(1'b1);
    dig_in <= 1'b1;
    idle();
    check("di once", count_value, 32'h0000_0065);
    apb(1'b1, ECI_STAT_OFS, 32'h0000_0001);
    dig_in <= 1'b0;
    idle();
    dig_in <= 1'b1;
    idle();
    check("di again", count_value, 32'h0000_0064);
    rd_chk(ECI_STAT_OFS, 32'h0000_0001);
    // digital capture and zero capture together
    dig_in <= 1'b0;
    apb(1'b1, ECI_CTRL_OFS, 32'h0006_b101);
    idle();
    dig_in <= 1'b1;
    idle();
    rd_chk(ECI_CAPT_OFS, 32'h0000_0064);
    i_enc.quad(1'b1);
    i_enc.pulse(2, 24);
    idle();
    check("n capture", captured_count_output, 32'h0000_0065);
    rd_chk(ECI_STAT_OFS, 32'h0000_0003);
    apb(1'b1, ECI_STAT_OFS, 32'h0000_0003);
    rd_chk(ECI_STAT_OFS, 32'h0000_0000);
    print_verdict();
  end

  // cuts a hang short
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
endmodule
